// File: design/link_ctrl_map.vh
// Register offsets, field positions, reset values and constants for the link control bank.
// Assumes inclusion by bare name from design files of this block.
`ifndef LINK_CTRL_MAP_VH
`define LINK_CTRL_MAP_VH

// ==========================================================================
// Register offsets
`define OFS_SAMPLE_LSB_CONTROL 12'h160
`define OFS_LINK_ENABLE 12'h200
`define OFS_LINK_OUTPUT_MODE 12'h201
`define OFS_FRAMES_PER_MF_M1 12'h202
`define OFS_LINK_STATUS 12'h210

// ==========================================================================
// Reset values
`define RST_SAMPLE_LSB_CONTROL 8'h00
`define RST_LINK_ENABLE 8'h01
`define RST_LINK_OUTPUT_MODE 8'h00
`define RST_FRAMES_PER_MF_M1 8'h1f

// ==========================================================================
// Field positions and widths
`define STAMP_BIT_ENABLE_BIT 0
`define LINK_ENABLE_BIT 0
`define MODE_MSB 5
`define MODE_WIDTH 6
`define REG_WIDTH 8
`define ADDR_WIDTH 12

// ==========================================================================
// Derived-K and alignment constants
`define K_64B66B_SCALE 256
`define K_WIDTH 12
`define ILA_CS_VALUE 2'h0

`endif

// File: design/mode_decode.v
// Output-mode decoder: derives encoding and E/F for the selected mode.
// Assumes the mode field is stable while the link is enabled.
`timescale 1ns/1ps
`include "link_ctrl_map.vh"

module mode_decode #(
    parameter FIRST_66B_MODE = 6'h14
) (
    // Mode select
    input wire [`MODE_WIDTH-1:0] mode,
    // Derived parameters
    output reg is_64b66b,
    output reg [3:0] octets_f,
    output reg [3:0] blocks_e
);

    // ======================================================================
    // Decode
    // Table contents are not modelled; a plain split by mode index stands in.
    always @* begin
        is_64b66b = (mode >= FIRST_66B_MODE);
        octets_f = {2'h0, mode[1:0]} + 4'h1;
        blocks_e = {3'h0, mode[2]} + 4'h1;
    end

endmodule // mode_decode

// File: design/sample_lsb_insert.v
// Places the timestamp bit at the LSB of the N-bit link sample field.
// Assumes timestamp arrives already delayed to match the sample path.
`timescale 1ns/1ps
`include "link_ctrl_map.vh"

module sample_lsb_insert #(
    parameter ADC_WIDTH = 12,
    parameter N_WIDTH = 16
) (
    // Inputs
    input wire stamp_bit_enable,
    input wire stamp_in,
    input wire [ADC_WIDTH-1:0] adc_sample,
    // Output field
    output reg [N_WIDTH-1:0] link_sample
);

    // ======================================================================
    // Merge
    // When N exceeds the ADC width the sample sits above the spare bits,
    // so the stamp never clobbers the converter LSB.
    always @* begin
        link_sample = {adc_sample, {(N_WIDTH-ADC_WIDTH){1'b0}}};
        if (stamp_bit_enable) begin
            link_sample[0] = stamp_in; // [RL1]
        end
    end

endmodule // sample_lsb_insert

// File: design/serial_link_control_regs.v
// Control register bank for the serial link transmit subsystem.
// Assumes a single-cycle register port synchronous to REF_CLK.
//
// Rules for this block and the software that drives it
// [RL1] With stamp enable set, timestamp input rides in each sample word LSB.
// [RL2] Timestamp path latency equals analog sample path latency.
// [RL3] Software should also enable the stamp receiver when using stamp bit.
// [RL4] With N wider than converter width, stamp uses N-field LSB, not sample LSB.
// [RL5] Lane alignment sequence always reports zero control bits.
// [RL6] Link enable: 0 disables, 1 enables; resets to 1.
// [RL7] Software clears link enable before changing other link registers.
// [RL8] Link enable low holds link in reset, powers serializers down, gates clocks.
// [RL9] Link enable low holds multiframe counter in reset, ignoring SYSREF.
// [RL10] Software sets calibration enable before link enable.
// [RL11] Software clears link enable before calibration enable.
// [RL12] Six-bit output mode field selects lanes, encoding, frame parameters. The code decodes encoding, E and F only, not lanes.
// [RL13] Mode changes only with link and calibration enables both low.
// [RL14] Frames-per-multiframe register holds K minus one; resets to 31.
// [RL15] Software programs only K values legal for the mode.
// [RL16] In 64B/66B modes K is 256*E/F, register ignored.
// [RL17] K register changes only while link enable is low.
// [RL18] Software writes reserved bits as zero.
// [RL19] Reset loads listed values; registers read back as written.
`timescale 1ns/1ps
`include "link_ctrl_map.vh"

module serial_link_control_regs #(
    parameter ADC_WIDTH = 12,
    parameter N_WIDTH = 16,
    parameter SAMPLE_DELAY = 4
) (
    // Clock and reset
    input wire REF_CLK,
    input wire RESET,
    // Register port
    input wire [`ADDR_WIDTH-1:0] ADDR,
    input wire [`REG_WIDTH-1:0] WDATA,
    input wire WR,
    input wire RD,
    output reg [`REG_WIDTH-1:0] RDATA,
    // Sample path
    input wire [ADC_WIDTH-1:0] ADC_SAMPLE,
    input wire TIMESTAMP_IN,
    output reg [N_WIDTH-1:0] LINK_SAMPLE,
    // Link controls
    input wire SYSREF,
    output reg LINK_RESET,
    output reg SERIALIZER_POWER_DOWN,
    output reg LINK_CLOCK_ENABLE,
    output reg [`MODE_WIDTH-1:0] OUTPUT_MODE,
    output reg IS_64B66B,
    output reg [`K_WIDTH-1:0] K_EFFECTIVE,
    output reg [1:0] ILA_CS,
    output reg [`K_WIDTH-1:0] MF_COUNT
);

    // ======================================================================
    // Registers
    reg [`REG_WIDTH-1:0] lsb_control_reg;
    reg [`REG_WIDTH-1:0] link_enable_reg;
    reg [`REG_WIDTH-1:0] output_mode_reg;
    reg [`REG_WIDTH-1:0] frames_m1_reg;
    reg [`REG_WIDTH-1:0] rdata_next;

    wire link_on = link_enable_reg[`LINK_ENABLE_BIT];
    wire stamp_on = lsb_control_reg[`STAMP_BIT_ENABLE_BIT];

    always @(posedge REF_CLK) begin
        if (RESET) begin
            lsb_control_reg <= `RST_SAMPLE_LSB_CONTROL; // [RL19]
            link_enable_reg <= `RST_LINK_ENABLE; // [RL6]
            output_mode_reg <= `RST_LINK_OUTPUT_MODE;
            frames_m1_reg <= `RST_FRAMES_PER_MF_M1; // [RL14]
        end else if (WR) begin
            if (ADDR == `OFS_SAMPLE_LSB_CONTROL) begin
                lsb_control_reg <= WDATA;
            end else if (ADDR == `OFS_LINK_ENABLE) begin
                link_enable_reg <= WDATA;
            end else if (ADDR == `OFS_LINK_OUTPUT_MODE) begin
                output_mode_reg <= WDATA;
            end else if (ADDR == `OFS_FRAMES_PER_MF_M1) begin
                frames_m1_reg <= WDATA;
            end
        end
    end

    // ======================================================================
    // Read port
    // Unmapped reads return zero; status reflects live link state.
    always @* begin
        rdata_next = 8'h00;
        if (ADDR == `OFS_SAMPLE_LSB_CONTROL) begin
            rdata_next = lsb_control_reg; // [RL19]
        end else if (ADDR == `OFS_LINK_ENABLE) begin
            rdata_next = link_enable_reg;
        end else if (ADDR == `OFS_LINK_OUTPUT_MODE) begin
            rdata_next = output_mode_reg;
        end else if (ADDR == `OFS_FRAMES_PER_MF_M1) begin
            rdata_next = frames_m1_reg;
        end else if (ADDR == `OFS_LINK_STATUS) begin
            rdata_next = {5'h00, IS_64B66B, LINK_CLOCK_ENABLE, LINK_RESET};
        end
    end

    always @(posedge REF_CLK) begin
        if (RESET) begin
            RDATA <= 8'h00;
        end else if (RD) begin
            RDATA <= rdata_next;
        end else begin
            RDATA <= 8'h00;
        end
    end

    // ======================================================================
    // Mode decode and effective K
    wire dec_66b;
    wire [3:0] dec_f;
    wire [3:0] dec_e;

    mode_decode u_mode_decode (
        .mode(output_mode_reg[`MODE_MSB:0]), // [RL12]
        .is_64b66b(dec_66b),
        .octets_f(dec_f),
        .blocks_e(dec_e)
    );

    // Divide done once per mode change, not per frame; mode is static in use.
    function [`K_WIDTH-1:0] k_from_ef;
        input [3:0] e;
        input [3:0] f;
        reg [`K_WIDTH+3:0] num;
        begin
            // Scale is a power of two, so a shift by concatenation keeps the width exact
            num = {4'h0, e, 8'h00};
            k_from_ef = num[`K_WIDTH-1:0] / {8'h00, f};
        end
    endfunction

    wire [`K_WIDTH-1:0] k_next = dec_66b ? k_from_ef(dec_e, dec_f) // [RL16]
        : ({4'h0, frames_m1_reg} + 12'h001); // [RL14]

    always @(posedge REF_CLK) begin
        if (RESET) begin
            OUTPUT_MODE <= 6'h00;
            IS_64B66B <= 1'b0;
            K_EFFECTIVE <= {4'h0, `RST_FRAMES_PER_MF_M1} + 12'h001;
            ILA_CS <= `ILA_CS_VALUE;
        end else begin
            OUTPUT_MODE <= output_mode_reg[`MODE_MSB:0]; // [RL12]
            IS_64B66B <= dec_66b;
            K_EFFECTIVE <= k_next;
            ILA_CS <= `ILA_CS_VALUE; // [RL5]
        end
    end

    // ======================================================================
    // Link enable effects
    always @(posedge REF_CLK) begin
        if (RESET) begin
            LINK_RESET <= 1'b1;
            SERIALIZER_POWER_DOWN <= 1'b1;
            LINK_CLOCK_ENABLE <= 1'b0;
        end else begin
            LINK_RESET <= ~link_on; // [RL8]
            SERIALIZER_POWER_DOWN <= ~link_on; // [RL8]
            LINK_CLOCK_ENABLE <= link_on; // [RL8]
        end
    end

    // Multiframe counter: cleared while disabled so SYSREF cannot realign it.
    always @(posedge REF_CLK) begin
        if (RESET || !link_on) begin
            MF_COUNT <= 12'h000; // [RL9]
        end else if (SYSREF || (MF_COUNT + 12'h001 >= K_EFFECTIVE)) begin
            MF_COUNT <= 12'h000;
        end else begin
            MF_COUNT <= MF_COUNT + 12'h001;
        end
    end

    // ======================================================================
    // Sample path
    // Stamp is delayed by the same pipeline depth as samples.
    reg [SAMPLE_DELAY-1:0] stamp_pipe;
    reg [ADC_WIDTH-1:0] sample_pipe [0:SAMPLE_DELAY-1];
    wire [N_WIDTH-1:0] merged;
    integer i;

    always @(posedge REF_CLK) begin
        if (RESET) begin
            stamp_pipe <= {SAMPLE_DELAY{1'b0}};
            for (i = 0; i < SAMPLE_DELAY; i = i + 1) begin
                sample_pipe[i] <= {ADC_WIDTH{1'b0}};
            end
        end else begin
            stamp_pipe[0] <= TIMESTAMP_IN; // [RL2]
            sample_pipe[0] <= ADC_SAMPLE;
            for (i = 1; i < SAMPLE_DELAY; i = i + 1) begin
                stamp_pipe[i] <= stamp_pipe[i-1];
                sample_pipe[i] <= sample_pipe[i-1];
            end
        end
    end

    sample_lsb_insert #(
        .ADC_WIDTH(ADC_WIDTH),
        .N_WIDTH(N_WIDTH)
    ) u_lsb_insert (
        .stamp_bit_enable(stamp_on),
        .stamp_in(stamp_pipe[SAMPLE_DELAY-1]),
        .adc_sample(sample_pipe[SAMPLE_DELAY-1]),
        .link_sample(merged) // [RL4]
    );

    always @(posedge REF_CLK) begin
        if (RESET || !link_on) begin
            LINK_SAMPLE <= {N_WIDTH{1'b0}}; // [RL8]
        end else begin
            LINK_SAMPLE <= merged; // [RL1]
        end
    end

endmodule // serial_link_control_regs

// File: verif/link_ctrl_chk.sv
// Port-level assertions for the link control register bank.
// Assumes a bind onto serial_link_control_regs and one clock domain.
`timescale 1ns/1ps
`include "link_ctrl_map.vh"

module link_ctrl_chk (
    // Clock and register port
    input wire REF_CLK,
    input wire RESET,
    input wire [`ADDR_WIDTH-1:0] ADDR,
    input wire [`REG_WIDTH-1:0] WDATA,
    input wire WR,
    input wire RD,
    input wire [`REG_WIDTH-1:0] RDATA,
    // Link controls
    input wire LINK_RESET,
    input wire SERIALIZER_POWER_DOWN,
    input wire LINK_CLOCK_ENABLE,
    input wire [`MODE_WIDTH-1:0] OUTPUT_MODE,
    input wire IS_64B66B,
    input wire [`K_WIDTH-1:0] K_EFFECTIVE,
    input wire [1:0] ILA_CS,
    input wire [`K_WIDTH-1:0] MF_COUNT
);
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (RESET);

    // ========================================
    // Write, then one cycle for the register to land
    sequence s_wr(a);
        WR && ADDR == a ##1 1'b1;
    endsequence
    sequence s_link_wr(v);
        WR && ADDR == `OFS_LINK_ENABLE && WDATA[0] == v ##1 1'b1;
    endsequence

    property p_rd_idle; !RD |=> RDATA == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
    property p_off; s_link_wr(1'b0) |=> LINK_RESET && SERIALIZER_POWER_DOWN && !LINK_CLOCK_ENABLE;
    endproperty
    a_off: assert property (p_off) else $error("link not held off");
    property p_on; s_link_wr(1'b1) |=> !LINK_RESET && !SERIALIZER_POWER_DOWN && LINK_CLOCK_ENABLE;
    endproperty
    a_on: assert property (p_on) else $error("link not enabled");
    property p_mode; s_wr(`OFS_LINK_OUTPUT_MODE) |=> {2'b00, OUTPUT_MODE} == $past(WDATA, 2);
    endproperty
    a_mode: assert property (p_mode) else $error("mode field mismatch");
    property p_k; s_wr(`OFS_FRAMES_PER_MF_M1) ##1 !IS_64B66B |-> K_EFFECTIVE == {4'h0, $past(WDATA, 2)} + 12'h001;
    endproperty
    a_k: assert property (p_k) else $error("K not register plus one");
    property p_k66; s_wr(`OFS_FRAMES_PER_MF_M1) ##1 IS_64B66B |-> $stable(K_EFFECTIVE); endproperty
    a_k66: assert property (p_k66) else $error("K follows register in 66b mode");
    property p_ila; ILA_CS == 2'h0; endproperty
    a_ila: assert property (p_ila) else $error("alignment control bits nonzero");
    property p_mf; LINK_RESET |-> MF_COUNT == 12'h000; endproperty
    a_mf: assert property (p_mf) else $error("multiframe counter runs while off");
endmodule // link_ctrl_chk

bind serial_link_control_regs link_ctrl_chk i_link_ctrl_chk (
    .REF_CLK(REF_CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .LINK_RESET(LINK_RESET), .SERIALIZER_POWER_DOWN(SERIALIZER_POWER_DOWN),
    .LINK_CLOCK_ENABLE(LINK_CLOCK_ENABLE), .OUTPUT_MODE(OUTPUT_MODE), .IS_64B66B(IS_64B66B),
    .K_EFFECTIVE(K_EFFECTIVE), .ILA_CS(ILA_CS), .MF_COUNT(MF_COUNT));

// File: verif/tb_top.sv
// Bench for the link control bank: registers, link controls, stamp bit.
// Assumes the design files and map header are on the include path.
`timescale 1ns/1ps
`include "link_ctrl_map.vh"

module tb_top;
    localparam SD = 4;
    reg clk;
    reg rst = 1'b1;
    reg wr_s = 1'b0, rd_s = 1'b0, ts = 1'b0, sysref = 1'b0;
    reg [11:0] addr = 12'h000, adc = 12'h000;
    reg [7:0] wdata = 8'h00;
    wire [7:0] rdata;
    wire [15:0] lsamp;
    wire lrst, pd, cken, is66;
    wire [5:0] omode;
    wire [11:0] keff, mf;
    wire [1:0] ila;
    integer fail_count = 0, compares = 0, m;

    serial_link_control_regs #(.SAMPLE_DELAY(SD)) i_serial_link_control_regs (
        .REF_CLK(clk), .RESET(rst), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
        .RDATA(rdata), .ADC_SAMPLE(adc), .TIMESTAMP_IN(ts), .LINK_SAMPLE(lsamp),
        .SYSREF(sysref), .LINK_RESET(lrst), .SERIALIZER_POWER_DOWN(pd),
        .LINK_CLOCK_ENABLE(cken), .OUTPUT_MODE(omode), .IS_64B66B(is66),
        .K_EFFECTIVE(keff), .ILA_CS(ila), .MF_COUNT(mf));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ========================================
    // Bus and check tasks; wr and rd each return 1 ns past an edge so outputs have settled
    task check(input [15:0] seen, input [15:0] exp);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                fail_count = fail_count + 1;
                $display("BAD %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask

    task wr(input [11:0] a, input [7:0] d);
        begin
            @(posedge clk);
            addr <= a;
            wdata <= d;
            wr_s <= 1'b1;
            @(posedge clk);
            wr_s <= 1'b0;
            @(posedge clk);
            #1;
        end
    endtask

    task rd(input [11:0] a, input [7:0] exp);
        begin
            @(posedge clk);
            addr <= a;
            rd_s <= 1'b1;
            @(posedge clk);
            rd_s <= 1'b0;
            #1;
            check(rdata, exp);
        end
    endtask

    task end_sim;
        begin
            $display("compares %0d fail_count %0d", compares, fail_count);
            if (fail_count == 0 && compares > 0) begin
                $display("*** PASS ***");
            end else begin
                $display("*** FAIL ***");
            end
            $finish;
        end
    endtask

    // ========================================
    // Main sequence
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd(`OFS_SAMPLE_LSB_CONTROL, 8'h00);
        rd(`OFS_LINK_ENABLE, 8'h01);
        rd(`OFS_LINK_OUTPUT_MODE, 8'h00);
        rd(`OFS_FRAMES_PER_MF_M1, 8'h1f);
        rd(`OFS_LINK_STATUS, 8'h02);
        rd(12'h161, 8'h00);
        check({lrst, pd, cken}, 3'h1);
        check(keff, 12'd32);
        check(ila, 2'h0);
        $display("test reset values done");
        wr(`OFS_LINK_ENABLE, 8'h00);
        check({lrst, pd, cken}, 3'h6);
        @(posedge clk);
        sysref <= 1'b1;
        @(posedge clk);
        sysref <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check(mf, 12'h000);
        rd(`OFS_LINK_STATUS, 8'h01);
        // Every mode code, with K written alongside to expose the 66b override
        for (m = 0; m < 64; m = m + 1) begin
            wr(`OFS_LINK_OUTPUT_MODE, m[7:0]);
            wr(`OFS_FRAMES_PER_MF_M1, m[7:0]);
            repeat (2) @(posedge clk);
            #1;
            check({is66, omode}, {m >= 20, m[5:0]});
            check(keff, m >= 20 ? 256 * (m[2] + 1) / (m[1:0] + 1) : m + 1);
        end
        wr(12'h203, 8'h55);
        rd(12'h203, 8'h00);
        wr(`OFS_LINK_OUTPUT_MODE, 8'h03);
        wr(`OFS_FRAMES_PER_MF_M1, 8'h03);
        rd(`OFS_FRAMES_PER_MF_M1, 8'h03);
        wr(`OFS_LINK_ENABLE, 8'h01);
        check({lrst, pd, cken}, 3'h1);
        repeat (12) @(posedge clk);
        #1;
        check(mf < 12'd4, 1'b1);
        @(posedge clk);
        sysref <= 1'b1;
        @(posedge clk);
        sysref <= 1'b0;
        #1;
        check(mf, 12'h000);
        $display("test link control done");
        wr(`OFS_SAMPLE_LSB_CONTROL, 8'h01);
        @(posedge clk);
        adc <= 12'h5a5;
        ts <= 1'b1;
        repeat (SD) @(posedge clk);
        #1;
        check(lsamp, 16'h0000);
        @(posedge clk);
        #1;
        check(lsamp, 16'h5a51);
        wr(`OFS_SAMPLE_LSB_CONTROL, 8'h00);
        repeat (SD + 3) @(posedge clk);
        #1;
        check(lsamp, 16'h5a50);
        wr(`OFS_LINK_ENABLE, 8'h00);
        @(posedge clk);
        #1;
        check(lsamp, 16'h0000);
        $display("test sample stamp done");
        end_sim;
    end
endmodule // tb_top
